//--- tssc_top.sv
// module: two-speed start-up clock control with register port
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/10ps
module tssc_top (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       por_i,
  // register port
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // oscillator side
  input  wire logic       primary_ready_i,
  input  wire logic       wake_i,
  // clock control outputs
  output logic            use_primary_o,
  output logic      [2:0] freq_select_o,
  output logic      [1:0] clock_select_o,
  output logic            sleeping_o
);

  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------
  logic [2:0]  ifs_reg;
  logic [1:0]  scs_reg;
  logic [7:0]  cfg_reg;
  logic        idle_reg;
  logic        por_seen_reg;
  logic        ready_meta_reg;
  logic        ready_sync_reg;
  logic        wake_meta_reg;
  logic        wake_sync_reg;
  logic        wake_prev_reg;
  logic [10:0] ost_reg;
  logic [7:0]  pwrt_reg;
  logic        ost_done;
  logic        two_speed;
  logic        want_primary;
  logic        use_primary;
  logic        pausing;
  logic        wake_rise;
  logic        sleep_cmd;
  logic [7:0]  rdata_next;
  tssc_pkg::tssc_state_t state_reg;
  tssc_pkg::tssc_state_t state_next;

  // crystal modes only permit two-speed start-up
  function automatic logic is_crystal(input logic [3:0] mode);
    is_crystal = (mode == tssc_pkg::MODE_LOW_POWER_XTAL) ||
                 (mode == tssc_pkg::MODE_STANDARD_XTAL) ||
                 (mode == tssc_pkg::MODE_HIGH_SPEED_XTAL) ||
                 (mode == tssc_pkg::MODE_HS_MULTIPLIED);
  endfunction

  //----------------------------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------------------------
  // pins come from other domains, two flops before use
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ready_meta_reg <= 1'b0;
      ready_sync_reg <= 1'b0;
      wake_meta_reg  <= 1'b0;
      wake_sync_reg  <= 1'b0;
      wake_prev_reg  <= 1'b0;
    end else begin
      ready_meta_reg <= primary_ready_i;
      ready_sync_reg <= ready_meta_reg;
      wake_meta_reg  <= wake_i;
      wake_sync_reg  <= wake_meta_reg;
      wake_prev_reg  <= wake_sync_reg;
    end
  end

  assign wake_rise = wake_sync_reg & ~wake_prev_reg;
  assign sleep_cmd = wr_i && (addr_i == tssc_pkg::ADDR_COMMAND) &&
                     wdata_i[tssc_pkg::CMD_SLEEP];

  // enable only from config bit 7 and a crystal mode
  assign two_speed = cfg_reg[tssc_pkg::FLD_ENABLE] &&
                     is_crystal(cfg_reg[tssc_pkg::FLD_MODE_LSB +: 4]);

  //----------------------------------------------------------------------------
  // software registers
  //----------------------------------------------------------------------------
  // rst_i clears control; config survives non-power-on resets
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ifs_reg  <= tssc_pkg::OSC_CTRL_RESET[tssc_pkg::FLD_IFS_LSB +: 3];
      scs_reg  <= tssc_pkg::OSC_CTRL_RESET[tssc_pkg::FLD_SCS_LSB +: 2];
      idle_reg <= 1'b0;
    end else if (wr_i && addr_i == tssc_pkg::ADDR_OSC_CTRL) begin
      // accepted at any time, also before the timer runs out
      ifs_reg <= wdata_i[tssc_pkg::FLD_IFS_LSB +: 3];
      scs_reg <= wdata_i[tssc_pkg::FLD_SCS_LSB +: 2];
    end else if (wr_i && addr_i == tssc_pkg::ADDR_COMMAND) begin
      idle_reg <= wdata_i[tssc_pkg::CMD_IDLE];
    end
  end

  // configuration byte, written like a programmed fuse
  always_ff @(posedge clock_i) begin
    if (por_i) begin
      cfg_reg <= tssc_pkg::CONFIG_RESET;
    end else if (wr_i && addr_i == tssc_pkg::ADDR_CONFIG) begin
      cfg_reg <= wdata_i;
    end
  end

  // remember a power-on so the power-up timer runs first
  always_ff @(posedge clock_i) begin
    if (por_i) begin
      por_seen_reg <= 1'b1;
    end else if (state_reg != tssc_pkg::ST_PWRUP) begin
      // cleared on leaving power-up, also when two-speed is off
      por_seen_reg <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // timers
  //----------------------------------------------------------------------------
  // power-up timer, only after a power-on reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pwrt_reg <= 8'h00;
    end else if (state_reg == tssc_pkg::ST_PWRUP) begin
      pwrt_reg <= pwrt_reg + 8'h01;
    end else begin
      pwrt_reg <= 8'h00;
    end
  end

  // start-up timer counts clock cycles while the primary is ready; restarts on sleep
  always_ff @(posedge clock_i) begin
    if (rst_i || state_reg == tssc_pkg::ST_SLEEP) begin
      ost_reg <= 11'h000;
    end else if (ready_sync_reg && !ost_done) begin
      ost_reg <= ost_reg + 11'h001;
    end
  end

  assign ost_done = (ost_reg == 11'(tssc_pkg::OST_CYCLES));

  //----------------------------------------------------------------------------
  // run state machine
  //----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tssc_pkg::ST_PWRUP: begin
        if (!por_seen_reg ||
            pwrt_reg >= 8'(tssc_pkg::PWRT_CYCLES - 1)) begin
          state_next = two_speed ? tssc_pkg::ST_INT : tssc_pkg::ST_PRI;
        end
      end
      tssc_pkg::ST_INT: begin
        // sleep still honoured while on the internal source
        if (sleep_cmd && !idle_reg) begin
          state_next = tssc_pkg::ST_SLEEP;
        end else if (ost_done) begin
          state_next = tssc_pkg::ST_PRI;
        end
      end
      tssc_pkg::ST_PRI: begin
        if (sleep_cmd && !idle_reg) begin
          state_next = tssc_pkg::ST_SLEEP;
        end
      end
      tssc_pkg::ST_SLEEP: begin
        if (wake_rise) begin
          state_next = two_speed ? tssc_pkg::ST_INT
                                 : tssc_pkg::ST_PRI;
        end
      end
      default: state_next = tssc_pkg::ST_PWRUP;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= tssc_pkg::ST_PWRUP;
    end else begin
      state_reg <= state_next;
    end
  end

  // idle modes keep the selected source; enable bit plays no part there
  // primary is used only once the start-up timer has expired
  always_comb begin
    if (state_reg == tssc_pkg::ST_INT) begin
      want_primary = 1'b0;
    end else if (idle_reg) begin
      want_primary = (scs_reg == tssc_pkg::SEL_PRIMARY) && ost_done;
    end else begin
      want_primary = (state_reg == tssc_pkg::ST_PRI) && ost_done &&
                     (scs_reg == tssc_pkg::SEL_PRIMARY);
    end
  end

  tssc_switch u_switch (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .want_primary_i (want_primary),
    .use_primary_o  (use_primary),
    .pausing_o      (pausing)
  );

  //----------------------------------------------------------------------------
  // outputs and read port
  //----------------------------------------------------------------------------
  // frequency select held through sleep applies on wake
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      use_primary_o  <= 1'b0;
      freq_select_o  <= 3'h0;
      clock_select_o <= 2'h0;
      sleeping_o     <= 1'b0;
    end else begin
      use_primary_o  <= use_primary;
      freq_select_o  <= ifs_reg;
      clock_select_o <= scs_reg;
      sleeping_o     <= (state_reg == tssc_pkg::ST_SLEEP);
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    case (addr_i)
      tssc_pkg::ADDR_OSC_CTRL: begin
        rdata_next[tssc_pkg::FLD_IFS_LSB +: 3] = ifs_reg;
        rdata_next[tssc_pkg::FLD_SCS_LSB +: 2] = scs_reg;
        rdata_next[tssc_pkg::FLD_RUNNING]      = use_primary;
      end
      tssc_pkg::ADDR_CONFIG: rdata_next = cfg_reg;
      default:               rdata_next = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  a_reset_clears: assert property (@(posedge clock_i)
    $fell(rst_i) |-> (ifs_reg == 3'h0) && (scs_reg == 2'h0) && !use_primary)
    else $error("control not cleared by reset");

  a_int_no_primary: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == tssc_pkg::ST_INT) |-> !want_primary)
    else $error("primary requested during internal start");

  a_ost_to_pri: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == tssc_pkg::ST_INT) && ost_done && !sleep_cmd
    |=> (state_reg == tssc_pkg::ST_PRI))
    else $error("no switch at timer expiry");

  a_sleep_accept: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == tssc_pkg::ST_INT) && sleep_cmd && !idle_reg
    |=> (state_reg == tssc_pkg::ST_SLEEP))
    else $error("sleep refused on internal clock");

  a_scs_write: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_i && (addr_i == tssc_pkg::ADDR_OSC_CTRL) |=> (scs_reg == $past(wdata_i[1:0])))
    else $error("clock select write lost");

  a_running_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    rd_i && (addr_i == tssc_pkg::ADDR_OSC_CTRL)
    |=> (rdata_o[3] == $past(use_primary)))
    else $error("running flag wrong");

  a_wake_internal: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == tssc_pkg::ST_SLEEP) && wake_rise && two_speed
    |=> (state_reg == tssc_pkg::ST_INT))
    else $error("sleep wake skipped internal clock");

  a_mode_gate: assert property (@(posedge clock_i) disable iff (rst_i)
    !is_crystal(cfg_reg[3:0]) && (state_reg != tssc_pkg::ST_INT)
    |=> (state_reg != tssc_pkg::ST_INT))
    else $error("two-speed on non-crystal mode");

  // power-up timer must run out before any run state after power-on
  a_pwrup_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == tssc_pkg::ST_PWRUP) && por_seen_reg &&
    (pwrt_reg < 8'(tssc_pkg::PWRT_CYCLES - 1))
    |=> (state_reg == tssc_pkg::ST_PWRUP))
    else $error("power-up timer cut short");

  // primary may only take over once the start-up timer has expired
  a_primary_late: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(use_primary) |-> $past(ost_done))
    else $error("primary used before timer expiry");

  a_idle_no_ts: assert property (@(posedge clock_i) disable iff (rst_i)
    idle_reg && (state_reg != tssc_pkg::ST_INT) && (scs_reg != 2'h0)
    |-> !want_primary)
    else $error("idle wake left selected source");

endmodule // tssc_top

//--- tssc_pkg.sv
// package: constants for the two-speed start-up clock control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package tssc_pkg;

  // register map of the plain register port
  localparam logic [1:0] ADDR_OSC_CTRL = 2'h0;
  localparam logic [1:0] ADDR_CONFIG   = 2'h1;
  localparam logic [1:0] ADDR_COMMAND  = 2'h2;

  // oscillator control register fields
  localparam int FLD_SCS_LSB   = 0;
  localparam int FLD_RUNNING   = 3;
  localparam int FLD_IFS_LSB   = 4;
  localparam logic [7:0] OSC_CTRL_RESET = 8'h00;

  // config byte one high fields
  localparam int FLD_MODE_LSB  = 0;
  localparam int FLD_ENABLE    = 7;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // command register bits
  localparam int CMD_SLEEP     = 0;
  localparam int CMD_IDLE      = 1;

  // primary oscillator modes (crystal-based ones are the first four)
  localparam logic [3:0] MODE_LOW_POWER_XTAL = 4'h0;
  localparam logic [3:0] MODE_STANDARD_XTAL  = 4'h1;
  localparam logic [3:0] MODE_HIGH_SPEED_XTAL = 4'h2;
  localparam logic [3:0] MODE_HS_MULTIPLIED  = 4'h3;

  // clock select values
  localparam logic [1:0] SEL_PRIMARY  = 2'h0;
  localparam logic [1:0] SEL_INTERNAL = 2'h2;

  // timing
  localparam int CLOCK_NS      = 40;
  localparam int OST_CYCLES    = 1024;
  localparam int PWRT_NS       = 2000;
  localparam int PWRT_CYCLES   = (PWRT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int SWITCH_CYCLES = 9;

  // power state machine
  typedef enum logic [3:0] {
    ST_PWRUP = 4'b0001,
    ST_INT   = 4'b0010,
    ST_PRI   = 4'b0100,
    ST_SLEEP = 4'b1000
  } tssc_state_t;

endpackage

//--- tssc_switch.sv
// module: glitch-free hand-over between internal and primary clock
`timescale 1ns/10ps
module tssc_switch (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // request and result
  input  wire logic want_primary_i,
  output logic      use_primary_o,
  output logic      pausing_o
);

  logic [3:0] pause_reg;
  logic       use_reg;

  // the source changes only after a quiet pause of several clocks, so
  // no shortened pulse reaches the system clock
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pause_reg <= 4'h0;
      use_reg   <= 1'b0;
    end else if (want_primary_i != use_reg) begin
      if (pause_reg == 4'(tssc_pkg::SWITCH_CYCLES - 1)) begin
        pause_reg <= 4'h0;
        use_reg   <= want_primary_i;
      end else begin
        pause_reg <= pause_reg + 4'h1;
      end
    end else begin
      pause_reg <= 4'h0;
    end
  end

  assign use_primary_o = use_reg;
  assign pausing_o     = (want_primary_i != use_reg);

  // a source change must follow the full quiet pause, never cut it short
  a_switch_pause: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(use_reg) |->
    ($past(pause_reg) == 4'(tssc_pkg::SWITCH_CYCLES - 1)))
    else $error("clock switched without pause");

endmodule // tssc_switch

//--- tssc_osc_model.sv
// partner model: primary crystal oscillator start-up as seen at its pin
`timescale 1ns/10ps
module tssc_osc_model #(
  parameter int FAST_CYCLES = 20,
  parameter int SLOW_CYCLES = 300
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // start-up speed and device state
  input  wire logic slow_i,
  input  wire logic sleeping_i,
  // oscillator status pin
  output logic      ready_o
);
  //----------------------------------------------------------------------------
  // start-up counter
  //----------------------------------------------------------------------------
  int unsigned count_reg;

  // crystal stops in sleep, so every wake needs a fresh start-up
  always_ff @(posedge clock_i) begin
    if (rst_i || sleeping_i) begin
      count_reg <= 0;
      ready_o   <= 1'b0;
    end else if (count_reg < (slow_i ? SLOW_CYCLES : FAST_CYCLES)) begin
      count_reg <= count_reg + 1;
    end else begin
      ready_o <= 1'b1; // stays up until next sleep or reset
    end
  end
endmodule // tssc_osc_model

//--- two_speed_startup_clock_tb_top.sv
// testbench: two-speed start-up clock control with oscillator model
`timescale 1ns/10ps
module two_speed_startup_clock_tb_top;
  //----------------------------------------------------------------------------
  // stimulus, model and checking
  //----------------------------------------------------------------------------
  logic        clock_i = 0, rst_i = 1, por_i = 1, wr_i = 0, rd_i = 0;
  logic        wake_i = 0, slow = 0, ready, rd_seen = 0;
  logic        use_primary_o, sleeping_o;
  logic [1:0]  addr_i = 2'h0, clock_select_o;
  logic [7:0]  wdata_i = 8'h00, rdata_o;
  logic [2:0]  freq_select_o;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'h7553;
  int          fails = 0, samples_checked = 0, cnt;

  // 25 MHz system clock
  always #20 clock_i = ~clock_i;

  tssc_top dut (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .primary_ready_i(ready), .wake_i(wake_i),
    .use_primary_o(use_primary_o), .freq_select_o(freq_select_o),
    .clock_select_o(clock_select_o), .sleeping_o(sleeping_o));

  tssc_osc_model osc (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow),
    .sleeping_i(sleeping_o), .ready_o(ready));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input string name, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one-cycle write strobe; the leading edge keeps strobes apart
  task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  // read strobe; the expected byte is noted for the monitor
  task automatic bus_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask

  // wake pin held long enough to pass the two-flop synchroniser
  task automatic wake_pulse;
    @(posedge clock_i);
    wake_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    wake_i <= 1'b0;
    repeat (6) @(negedge clock_i);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clock_i) rd_seen <= rd_i;
  always @(negedge clock_i) begin
    if (rd_seen)
      check("rdata", rdata_o, exp_q.pop_front()); // read back
  end

  // whole run is near 1500 cycles; cut a hang well beyond that
  initial begin
    #2_000_000;
    fails++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    @(negedge clock_i);
    check("use_primary", {7'h0, use_primary_o}, 8'h00); // internal
    check("freq_sel", {5'h0, freq_select_o}, 8'h00); // base rate
    check("clk_sel", {6'h0, clock_select_o}, 8'h00); // cleared
    bus_rd(2'h0, 8'h00); // control cleared
    repeat (60) @(posedge clock_i); // let the power-up timer run out
    bus_wr(2'h1, 8'h82); // enable with fast crystal mode
    bus_wr(2'h0, 8'h70); // fastest internal choice
    bus_rd(2'h1, 8'h82); // config kept
    bus_rd(2'h0, 8'h70); // still internal clock
    bus_rd(2'h3, 8'h00); // unmapped address reads zero
    @(negedge clock_i);
    check("freq_sel", {5'h0, freq_select_o}, 8'h07); // choice seen
    // sleep twice before the start-up timer ends, slow crystal second time
    for (int i = 0; i < 2; i++) begin
      bus_wr(2'h2, 8'h01); // sleep command
      repeat (3) @(negedge clock_i);
      check("sleeping", {7'h0, sleeping_o}, 8'h01); // asleep
      slow <= (i == 1);
      wake_pulse();
      check("sleeping", {7'h0, sleeping_o}, 8'h00); // awake
      check("use_primary", {7'h0, use_primary_o}, 8'h00); // internal
      check("freq_sel", {5'h0, freq_select_o}, 8'h07); // held choice
    end
    // slow crystal: 300 cycles, then 1024 timer cycles and the switch pause
    cnt = 0;
    while (use_primary_o !== 1'b1 && cnt < 2000) begin
      @(negedge clock_i);
      cnt++;
    end
    check("ost_span", {7'h0, cnt >= 1300 && cnt <= 1500}, 8'h01);
    bus_rd(2'h0, 8'h78); // running flag set on primary
    // idle bit set: sleep refused, enable cleared, primary kept
    bus_wr(2'h1, 8'h02); // enable dropped while running
    bus_wr(2'h2, 8'h02); // idle flag stored first
    bus_wr(2'h2, 8'h03); // idle plus sleep
    repeat (3) @(negedge clock_i);
    check("sleeping", {7'h0, sleeping_o}, 8'h00); // stays running
    check("use_primary", {7'h0, use_primary_o}, 8'h01); // kept
    // random internal choices while the primary drives the clock
    repeat (8) begin
      seed = xs(seed);
      bus_wr(2'h0, {1'b0, seed[6:4], 4'h0}); // new choice
      bus_rd(2'h0, {1'b0, seed[6:4], 4'h8}); // flag still set
      @(negedge clock_i);
      check("freq_sel", {5'h0, freq_select_o}, {5'h0, seed[6:4]});
    end
    // internal source selected while idle: primary dropped after the pause
    bus_wr(2'h0, 8'h72); // internal select kept while idle
    repeat (12) @(posedge clock_i);
    bus_rd(2'h0, 8'h72); // flag clear on internal source
    @(negedge clock_i);
    check("use_primary", {7'h0, use_primary_o}, 8'h00);
    // non-power-on reset mid-run: control cleared, config kept
    bus_wr(2'h1, 8'h84); // enable with a non-crystal mode
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    check("use_primary", {7'h0, use_primary_o}, 8'h00); // internal
    check("freq_sel", {5'h0, freq_select_o}, 8'h00); // base rate
    check("clk_sel", {6'h0, clock_select_o}, 8'h00); // cleared
    bus_rd(2'h0, 8'h00); // control cleared again
    bus_rd(2'h1, 8'h84); // config survives
    repeat (3) @(posedge clock_i);
    conclude();
  end
endmodule // two_speed_startup_clock_tb_top
